/* File: scr_window_map.vh */
`ifndef SCR_WINDOW_MAP_VH
`define SCR_WINDOW_MAP_VH
// =====================================================================
// address map
`define SCR_ADDR_W          32
`define SCR_DATA_W          32
`define SCR_PERIPH_LO       32'hFFD0_0000
`define SCR_SLOT_LSB        14
`define SCR_SLOT_MSB        21
`define SCR_SLOT_W          8
`define SCR_SLOT_OFS_W      14
`define SCR_INTC_BASE       32'hFFFF_F000
`define SCR_INTC_OFS_W      12
`define SCR_INTC_SLOT_NUM   8'hFF
`define SCR_WIN_BASE        32'hFFFE_0000
// upper address bits that pick the interrupt and window slots
`define SCR_INTC_TAG        20'hF_FFFF
`define SCR_WIN_TAG         18'h3_FFF8
// =====================================================================
// register groups inside the window slot
`define SCR_NUM_REGS        4
`define SCR_REG_IDX_W       2
`define SCR_GRP_LSB         4
`define SCR_GRP_MSB         13
`define SCR_ALIAS_LSB       2
`define SCR_ALIAS_MSB       3
`define SCR_ALIAS_SET       2'h0
`define SCR_ALIAS_CLR       2'h1
`define SCR_ALIAS_VAL       2'h2
`define SCR_ZERO32          32'h0000_0000
`define SCR_ZERO8           8'h00
`endif

/* File: scr_bitreg.v */
`include "scr_window_map.vh"
// =====================================================================
// one stored register with set and clear aliases
module scr_bitreg (
   input  wire                   clk_in,
   input  wire                   arst_n_in,
   input  wire                   set_en_in,
   input  wire                   clr_en_in,
   input  wire [`SCR_DATA_W-1:0] wdata_in,
   output wire [`SCR_DATA_W-1:0] value_out
);
   reg  [`SCR_DATA_W-1:0] value_q;
   wire [`SCR_DATA_W-1:0] set_mask;
   wire [`SCR_DATA_W-1:0] clr_mask;
   wire [`SCR_DATA_W-1:0] value_d;

   assign set_mask  = set_en_in ? wdata_in : `SCR_ZERO32; // RULE5
   assign clr_mask  = clr_en_in ? wdata_in : `SCR_ZERO32; // RULE6
   assign value_d   = (value_q | set_mask) & ~clr_mask;   // RULE8
   assign value_out = value_q;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         value_q <= `SCR_ZERO32;
      end else begin
         value_q <= value_d;
      end
   end
endmodule

/* File: scr_window.v */
// Summary of operation
// RULE1 - each peripheral owns a 16 Kbyte slot in the top 3 Mbyte
// RULE2 - the interrupt controller slot is only 4 Kbyte wide
// RULE3 - slot base is its lowest address; offsets count up from it
// RULE4 - each aliased register answers at three addresses, one value
// RULE5 - writing the first alias sets every bit written as one
// RULE6 - writing the second alias clears every bit written as one
// RULE7 - reading the third alias returns the stored value
// RULE8 - bits written as zero keep their value on set or clear
// RULE9 - all register traffic arrives over the peripheral bus
// RULE10 - set and clear aliases read zero; value alias ignores writes
`include "scr_window_map.vh"
module scr_window (
   input  wire                                 clk_in,
   input  wire                                 arst_n_in,
   input  wire [`SCR_ADDR_W-1:0]               paddr_in,
   input  wire                                 psel_in,
   input  wire                                 penable_in,
   input  wire                                 pwrite_in,
   input  wire [`SCR_DATA_W-1:0]               pwdata_in,
   output reg  [`SCR_DATA_W-1:0]               prdata_out,
   output reg                                  slot_valid_out,
   output reg  [`SCR_SLOT_W-1:0]               slot_num_out,
   output reg                                  intc_sel_out,
   output wire [`SCR_NUM_REGS*`SCR_DATA_W-1:0] reg_values_out
);
   // ==================================================================
   // decode helpers
   function periph_hit;
      input [`SCR_ADDR_W-1:0] a;
      begin
         periph_hit = (a >= `SCR_PERIPH_LO); // RULE1
      end
   endfunction

   function intc_hit;
      input [`SCR_ADDR_W-1:0] a;
      begin
         intc_hit = (a[`SCR_ADDR_W-1:`SCR_INTC_OFS_W] ==
                     `SCR_INTC_TAG); // RULE2
      end
   endfunction

   function win_hit;
      input [`SCR_ADDR_W-1:0] a;
      begin
         // RULE3
         win_hit = (a[`SCR_ADDR_W-1:`SCR_SLOT_OFS_W] ==
                    `SCR_WIN_TAG) &&
                   (a[`SCR_GRP_MSB:`SCR_GRP_LSB] < `SCR_NUM_REGS);
      end
   endfunction

   function [`SCR_REG_IDX_W-1:0] grp_idx;
      input [`SCR_ADDR_W-1:0] a;
      begin
         grp_idx = a[`SCR_GRP_LSB+`SCR_REG_IDX_W-1:`SCR_GRP_LSB];
      end
   endfunction

   // ==================================================================
   // bus phases
   wire                      setup_rd;
   wire                      access_wr;
   wire                      hit;
   wire [1:0]                alias_sel;
   wire [`SCR_REG_IDX_W-1:0] idx;
   wire [`SCR_DATA_W-1:0]    values [0:`SCR_NUM_REGS-1];

   assign setup_rd  = psel_in & ~penable_in & ~pwrite_in;     // RULE9
   assign access_wr = psel_in & penable_in & pwrite_in;       // RULE9
   assign hit       = win_hit(paddr_in);
   assign alias_sel = paddr_in[`SCR_ALIAS_MSB:`SCR_ALIAS_LSB];
   assign idx       = grp_idx(paddr_in);

   // ==================================================================
   // aliased registers
   genvar g;
   generate
      for (g = 0; g < `SCR_NUM_REGS; g = g + 1) begin : g_reg
         wire sel;
         assign sel = access_wr & hit & (idx == g);            // RULE4
         scr_bitreg u_reg (
            .clk_in    (clk_in),
            .arst_n_in (arst_n_in),
            .set_en_in (sel & (alias_sel == `SCR_ALIAS_SET)),  // RULE5
            .clr_en_in (sel & (alias_sel == `SCR_ALIAS_CLR)),  // RULE6
            .wdata_in  (pwdata_in),
            .value_out (values[g])
         );
         assign reg_values_out[g*`SCR_DATA_W +: `SCR_DATA_W] = values[g];
      end
   endgenerate

   // ==================================================================
   // read data and slot decode
   reg [`SCR_DATA_W-1:0] rdata_d;

   always @* begin
      rdata_d = `SCR_ZERO32;
      if (hit && alias_sel == `SCR_ALIAS_VAL) begin
         rdata_d = values[idx];                                // RULE7
      end
      // other aliases and unmapped offsets return zero        RULE10
   end

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prdata_out     <= `SCR_ZERO32;
         slot_valid_out <= 1'b0;
         slot_num_out   <= `SCR_ZERO8;
         intc_sel_out   <= 1'b0;
      end else begin
         if (setup_rd) begin
            prdata_out <= rdata_d;                             // RULE10
         end
         slot_valid_out <= psel_in & periph_hit(paddr_in);     // RULE1
         slot_num_out   <= paddr_in[`SCR_SLOT_MSB:`SCR_SLOT_LSB];
         intc_sel_out   <= psel_in & intc_hit(paddr_in);       // RULE2
      end
   end
endmodule

/* File: scr_bridge_model.sv */
module scr_bridge_model (
   input  wire         clk_in,
   output logic        psel_out = 0,
   output logic        penable_out = 0,
   output logic        pwrite_out = 0,
   output logic [31:0] paddr_out = 0,
   output logic [31:0] pwdata_out = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================
   // setup, access, release; idle address and data inverted
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(negedge clk_in);
      psel_out = 1;
      pwrite_out = w;
      paddr_out = a;
      pwdata_out = d;
      @(negedge clk_in);
      penable_out = 1;
      @(negedge clk_in);
      psel_out = 0;
      penable_out = 0;
      paddr_out = ~a;
      pwdata_out = ~d;
   endtask
endmodule

/* File: scr_window_sva.sv */
module scr_window_sva (
   input wire         clk_in, arst_n_in, psel_in, penable_in, pwrite_in,
   input wire         slot_valid_out, intc_sel_out,
   input wire [31:0]  paddr_in, pwdata_in, prdata_out,
   input wire [7:0]   slot_num_out,
   input wire [127:0] reg_values_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   wire        wr = psel_in && penable_in && pwrite_in;
   wire        rd = psel_in && !penable_in && !pwrite_in;
   wire [31:0] r0 = reg_values_out[31:0];
   chk_slot_num: assert property (1 |=> slot_num_out == $past(paddr_in[21:14]))
      else $error("slot number wrong");
   chk_slot_valid: assert property (1 |=> slot_valid_out ==
      $past(psel_in && paddr_in >= 32'hffd0_0000)) else $error("slot valid");
   chk_intc_sel: assert property (1 |=> intc_sel_out ==
      $past(psel_in && paddr_in[31:12] == 20'hf_ffff)) else $error("intc");
   chk_set_bits: assert property (wr && paddr_in == 32'hfffe_0000 |=>
      r0 == ($past(r0) | $past(pwdata_in))) else $error("set alias");
   chk_clr_bits: assert property (wr && paddr_in == 32'hfffe_0004 |=>
      r0 == ($past(r0) & ~$past(pwdata_in))) else $error("clear alias");
   chk_read_val: assert property (rd && paddr_in == 32'hfffe_0008 |=>
      prdata_out == $past(r0)) else $error("value read");
   chk_read_zero: assert property (rd && paddr_in == 32'hfffe_0004 |=>
      prdata_out == 0) else $error("clear alias read");
   chk_val_ignore: assert property (wr && paddr_in == 32'hfffe_0008 |=>
      $stable(reg_values_out)) else $error("value alias written");
endmodule
bind scr_window scr_window_sva scr_window_sva_inst (.*);

/* File: tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, arst_n_in = 0;
   wire psel_in, penable_in, pwrite_in, slot_valid_out, intc_sel_out;
   wire [31:0] paddr_in, pwdata_in, prdata_out;
   wire [7:0] slot_num_out;
   wire [127:0] reg_values_out;
   int error_cnt = 0, num_checks = 0;
   logic [31:0] lfsr = 32'h230f_ad22, a, d, m[4] = '{default:0};
   logic [1:0] n, op;
   scr_window scr_window_inst (.*);
   scr_bridge_model scr_bridge_model_inst (.clk_in, .psel_out(psel_in),
      .penable_out(penable_in), .pwrite_out(pwrite_in),
      .paddr_out(paddr_in), .pwdata_out(pwdata_in));
   initial forever #4 clk_in = ~clk_in;
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (10) @(negedge clk_in);
      arst_n_in = 1;
      scr_bridge_model_inst.xfer(0, 32'hffff_f000, 0);
      chk(prdata_out, 0);
      chk(intc_sel_out, 1);
      chk(slot_num_out, 8'hff);
      chk(slot_valid_out, 1);
      for (int i = 0; i < 80; i++) begin
         lfsr = nxt(lfsr);
         d = nxt(lfsr);
         n = lfsr[5:4];
         op = lfsr[3:2];
         a = 32'hfffe_0000 | {n, op, 2'h0};
         scr_bridge_model_inst.xfer(lfsr[0], a, d);
         chk(slot_num_out, 8'hf8);
         chk(intc_sel_out, 0);
         if (lfsr[0] && op == 0) m[n] |= d;
         else if (lfsr[0] && op == 1) m[n] &= ~d;
         if (lfsr[0]) chk(reg_values_out[n*32+:32], m[n]);
         else chk(prdata_out, op == 2 ? m[n] : 0);
         if (i == 40) begin
            arst_n_in = 0;
            @(negedge clk_in);
            chk(reg_values_out[31:0], 0);
            m = '{default:0};
            arst_n_in = 1;
         end
      end
      end_sim;
   end
endmodule
